// ===== verilog/dlc_pkg.sv
`default_nettype none
package dlc_pkg;
  // channel count and code width
  localparam int NCH = 12;
  localparam int DW = 12;
  localparam int AW = 8;
  localparam int NSRC = 3;
  // register byte offsets, one 32-bit word each, except the data and clear-code windows of twelve words each
  localparam logic [7:0] OFF_CFG0 = 8'h00;
  localparam logic [7:0] OFF_SYNC = 8'h04;
  localparam logic [7:0] OFF_GAIN = 8'h08;
  localparam logic [7:0] OFF_MASK_A = 8'h0c;
  localparam logic [7:0] OFF_MASK_B = 8'h10;
  localparam logic [7:0] OFF_SWCLR = 8'h14;
  localparam logic [7:0] OFF_ASRC = 8'h18;
  localparam logic [7:0] OFF_AEN = 8'h1c;
  localparam logic [7:0] OFF_STAT = 8'h20;
  localparam logic [7:0] OFF_PWR = 8'h24;
  localparam logic [7:0] OFF_DATA = 8'h40;
  localparam logic [7:0] OFF_CCODE = 8'h80;
  // field positions
  localparam int TRIG_BIT = 0;
  localparam int OVERTEMP_BIT = 2;
  localparam int AEN_LSB = 3;
  localparam int STAT_PEND_LSB = 16;
  localparam int LANE1_LSB = 8;
  // reset values
  localparam logic [DW-1:0] RST_CODE = 12'h000;
  localparam logic [NCH-1:0] RST_CHMASK = 12'h000;
  localparam logic [NSRC-1:0] RST_SRC = 3'h0;
  // per-channel request bundle
  typedef struct packed {
    logic wr;
    logic [DW-1:0] wdata;
    logic sync_load_select;
    logic trig;
    logic clear;
    logic [DW-1:0] clear_code;
  } dlc_chan_in_t;
  // per-channel state bundle
  typedef struct packed {
    logic [DW-1:0] code;
    logic pending;
    logic cleared;
  } dlc_chan_out_t;
endpackage
`default_nettype wire

// ===== verilog/dlc_chan.sv
`timescale 1ns/100ps
`default_nettype none
module dlc_chan
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // request bundle
  input wire dlc_pkg::dlc_chan_in_t req,
  // state bundle
  output var dlc_pkg::dlc_chan_out_t st
);

  logic [dlc_pkg::DW-1:0] data_q;
  logic [dlc_pkg::DW-1:0] data_d;
  logic [dlc_pkg::DW-1:0] latch_q;
  logic [dlc_pkg::DW-1:0] latch_d;
  logic written_q;
  logic written_d;
  logic clr_q;
  logic enter_clr;
  logic leave_clr;
  logic trig_load;

  // input register follows every write, never disturbed by a clear
  assign data_d = req.wr ? req.wdata : data_q;
  // a write in the trigger cycle stays pending for the next trigger
  assign written_d = (written_q & ~req.trig) | (req.wr & req.sync_load_select);
  assign enter_clr = req.clear & ~clr_q;
  assign leave_clr = ~req.clear & clr_q;
  assign trig_load = req.sync_load_select & req.trig & written_q;

  // latch priority: clear, restore, transparent write, common trigger
  assign latch_d = enter_clr ? req.clear_code :
                   req.clear ? latch_q :
                   leave_clr ? data_d :
                   (req.wr & ~req.sync_load_select) ? req.wdata :
                   trig_load ? data_q :
                   latch_q;

  // channel registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      data_q <= dlc_pkg::RST_CODE;
      latch_q <= dlc_pkg::RST_CODE;
      written_q <= 1'b0;
      clr_q <= 1'b0;
    end
    else
    begin
      data_q <= data_d;
      latch_q <= latch_d;
      written_q <= written_d;
      clr_q <= req.clear;
    end
  end

  assign st.code = latch_q;
  assign st.pending = written_q;
  assign st.cleared = clr_q;

endmodule
`default_nettype wire

// ===== verilog/dlc_dac_ctrl.sv
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module dlc_dac_ctrl
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [dlc_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // clear pins, active low, asynchronous
  input wire logic hw_clear_in_a_n,
  input wire logic hw_clear_in_b_n,
  // alarm levels from on-chip monitors
  input wire logic [dlc_pkg::NSRC-1:0] alarm_in,
  // analog stage controls
  output logic [dlc_pkg::NCH-1:0][dlc_pkg::DW-1:0] dac_code,
  output logic [dlc_pkg::NCH-1:0] dac_gain_5x,
  output logic [dlc_pkg::NCH-1:0] dac_buf_power_up,
  output logic [dlc_pkg::NCH-1:0] dac_cleared
);

  localparam int NCH = dlc_pkg::NCH;
  localparam int DW = dlc_pkg::DW;
  localparam int NSRC = dlc_pkg::NSRC;
  localparam int AEN_MSB = dlc_pkg::AEN_LSB + NCH - 1;

  // channel slot decode shared by data and clear-code windows
  function automatic logic [4:0] chan_hit(input logic [7:0] addr, input logic [7:0] base);
    logic hit;
    hit = (addr[7:6] == base[7:6]) && (addr[1:0] == 2'h0) && (addr[5:2] < 4'(NCH));
    chan_hit = {hit, addr[5:2]};
  endfunction

  // byte-lane merge for twelve-bit fields
  function automatic logic [11:0] merge12(input logic [11:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge12[7:0] = be[0] ? wd[7:0] : old[7:0];
    merge12[11:8] = be[1] ? wd[11:8] : old[11:8];
  endfunction

  // bus handshake state
  logic ack_q;
  logic req_any;
  logic wr_fire;
  logic [31:0] rdata_q;
  logic [31:0] rd_word;

  // software registers
  logic [NCH-1:0] sync_q;
  logic [NCH-1:0] gain_q;
  logic [NCH-1:0] mask_a_q;
  logic [NCH-1:0] mask_b_q;
  logic [NCH-1:0] swclr_q;
  logic [NSRC-1:0] asrc_q;
  logic [NCH-1:0] aen_q;
  logic [NCH-1:0] pwr_q;
  logic [NCH-1:0][DW-1:0] ccode_q;
  logic trig_q;

  // pin synchronisers
  logic clr_a_meta_q;
  logic clr_a_sync_q;
  logic clr_b_meta_q;
  logic clr_b_sync_q;

  // address decode
  logic hit_cfg0;
  logic hit_sync;
  logic hit_gain;
  logic hit_mask_a;
  logic hit_mask_b;
  logic hit_swclr;
  logic hit_asrc;
  logic hit_aen;
  logic hit_stat;
  logic hit_pwr;
  logic [4:0] data_slot;
  logic [4:0] ccode_slot;
  logic hit_data;
  logic hit_ccode;
  logic [3:0] sel_idx;

  // per-register write strobes
  logic we_sync;
  logic we_gain;
  logic we_mask_a;
  logic we_mask_b;
  logic we_swclr;
  logic we_asrc;
  logic we_aen;
  logic we_pwr;

  // clear combination
  logic alarm_hit;
  logic [NCH-1:0] clear_vec;
  logic [NCH-1:0] pend_vec;
  logic [NCH-1:0] clr_state_vec;
  logic [NCH-1:0][DW-1:0] code_vec;
  logic [DW-1:0] latch_rd;
  logic [DW-1:0] ccode_rd;

  // one wait state on every access so read data can come from a flip-flop
  assign req_any = avs_read | avs_write;
  assign avs_waitrequest = req_any & ~ack_q;
  assign wr_fire = avs_write & ack_q;

  always_ff @(posedge mclk)
  begin
    if (srst)
      ack_q <= 1'b0;
    else
      ack_q <= req_any & ~ack_q;
  end

  // word decode
  assign hit_cfg0 = (avs_address == dlc_pkg::OFF_CFG0);
  assign hit_sync = (avs_address == dlc_pkg::OFF_SYNC);
  assign hit_gain = (avs_address == dlc_pkg::OFF_GAIN);
  assign hit_mask_a = (avs_address == dlc_pkg::OFF_MASK_A);
  assign hit_mask_b = (avs_address == dlc_pkg::OFF_MASK_B);
  assign hit_swclr = (avs_address == dlc_pkg::OFF_SWCLR);
  assign hit_asrc = (avs_address == dlc_pkg::OFF_ASRC);
  assign hit_aen = (avs_address == dlc_pkg::OFF_AEN);
  assign hit_stat = (avs_address == dlc_pkg::OFF_STAT);
  assign hit_pwr = (avs_address == dlc_pkg::OFF_PWR);
  assign data_slot = chan_hit(avs_address, dlc_pkg::OFF_DATA);
  assign ccode_slot = chan_hit(avs_address, dlc_pkg::OFF_CCODE);
  assign hit_data = data_slot[4];
  assign hit_ccode = ccode_slot[4];
  assign sel_idx = hit_data ? data_slot[3:0] : ccode_slot[3:0];

  // write strobes, only at the edge that completes a write
  assign we_sync = wr_fire & hit_sync;
  assign we_gain = wr_fire & hit_gain;
  assign we_mask_a = wr_fire & hit_mask_a;
  assign we_mask_b = wr_fire & hit_mask_b;
  assign we_swclr = wr_fire & hit_swclr;
  // narrow fields need their whole lanes so a half write cannot skew them
  assign we_asrc = wr_fire & hit_asrc & avs_byteenable[0];
  assign we_aen = wr_fire & hit_aen & avs_byteenable[0] & avs_byteenable[1];
  assign we_pwr = wr_fire & hit_pwr;

  // sync select register
  always_ff @(posedge mclk)
  begin
    if (srst)
      sync_q <= dlc_pkg::RST_CHMASK;
    else if (we_sync)
      sync_q <= merge12(sync_q, avs_writedata, avs_byteenable);
  end

  // gain register
  always_ff @(posedge mclk)
  begin
    if (srst)
      gain_q <= dlc_pkg::RST_CHMASK;
    else if (we_gain)
      gain_q <= merge12(gain_q, avs_writedata, avs_byteenable);
  end

  // pin a channel mask
  always_ff @(posedge mclk)
  begin
    if (srst)
      mask_a_q <= dlc_pkg::RST_CHMASK;
    else if (we_mask_a)
      mask_a_q <= merge12(mask_a_q, avs_writedata, avs_byteenable);
  end

  // pin b channel mask, independent of pin a
  always_ff @(posedge mclk)
  begin
    if (srst)
      mask_b_q <= dlc_pkg::RST_CHMASK;
    else if (we_mask_b)
      mask_b_q <= merge12(mask_b_q, avs_writedata, avs_byteenable);
  end

  // software clear, a level: channels stay cleared until written back to 0
  always_ff @(posedge mclk)
  begin
    if (srst)
      swclr_q <= dlc_pkg::RST_CHMASK;
    else if (we_swclr)
      swclr_q <= merge12(swclr_q, avs_writedata, avs_byteenable);
  end

  // alarm source select
  always_ff @(posedge mclk)
  begin
    if (srst)
      asrc_q <= dlc_pkg::RST_SRC;
    else if (we_asrc)
      asrc_q <= avs_writedata[NSRC-1:0];
  end

  // alarm channel enables
  always_ff @(posedge mclk)
  begin
    if (srst)
      aen_q <= dlc_pkg::RST_CHMASK;
    else if (we_aen)
      aen_q <= avs_writedata[AEN_MSB:dlc_pkg::AEN_LSB];
  end

  // buffer power-up, down after reset
  always_ff @(posedge mclk)
  begin
    if (srst)
      pwr_q <= dlc_pkg::RST_CHMASK;
    else if (we_pwr)
      pwr_q <= merge12(pwr_q, avs_writedata, avs_byteenable);
  end

  // clear-code words, one per channel
  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_ccode
      always_ff @(posedge mclk)
      begin
        if (srst)
          ccode_q[i] <= dlc_pkg::RST_CODE;
        else if (wr_fire && hit_ccode && (ccode_slot[3:0] == 4'(i)))
          ccode_q[i] <= merge12(ccode_q[i], avs_writedata, avs_byteenable);
      end
    end
  endgenerate

  // trigger is stored for one cycle only; cfg0 has no term in the read mux, so it reads back as zero
  always_ff @(posedge mclk)
  begin
    if (srst)
      trig_q <= 1'b0;
    else
      trig_q <= wr_fire & hit_cfg0 & avs_byteenable[0] & avs_writedata[dlc_pkg::TRIG_BIT];
  end

  // two flops on each pin; only the second flop is looked at
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      clr_a_meta_q <= 1'b1;
      clr_a_sync_q <= 1'b1;
      clr_b_meta_q <= 1'b1;
      clr_b_sync_q <= 1'b1;
    end
    else
    begin
      clr_a_meta_q <= hw_clear_in_a_n;
      clr_a_sync_q <= clr_a_meta_q;
      clr_b_meta_q <= hw_clear_in_b_n;
      clr_b_sync_q <= clr_b_meta_q;
    end
  end

  // any enabled alarm source clears every enabled channel
  assign alarm_hit = |(alarm_in & asrc_q);

  // or of all sources; clear ends only when all are gone
  assign clear_vec = ({NCH{~clr_a_sync_q}} & mask_a_q) |
                     ({NCH{~clr_b_sync_q}} & mask_b_q) |
                     swclr_q |
                     ({NCH{alarm_hit}} & aen_q);

  // channel instances
  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_chan
      dlc_pkg::dlc_chan_in_t req;
      dlc_pkg::dlc_chan_out_t st;

      assign req.wr = wr_fire & hit_data & (data_slot[3:0] == 4'(i));
      assign req.wdata = merge12(code_vec[i], avs_writedata, avs_byteenable);
      assign req.sync_load_select = sync_q[i];
      assign req.trig = trig_q;
      assign req.clear = clear_vec[i];
      assign req.clear_code = ccode_q[i];

      dlc_chan u_chan
      (
        .mclk(mclk),
        .srst(srst),
        .req(req),
        .st(st)
      );

      assign code_vec[i] = st.code;
      assign pend_vec[i] = st.pending;
      assign clr_state_vec[i] = st.cleared;
    end
  endgenerate

  // partial-lane writes merge against the latch, the only readable copy;
  // software wanting an exact pending value should write both lanes

  // read mux; unmapped words read zero
  assign latch_rd = code_vec[sel_idx];
  assign ccode_rd = ccode_q[sel_idx];
  assign rd_word = ({32{hit_sync}} & {20'h00000, sync_q}) |
                   ({32{hit_gain}} & {20'h00000, gain_q}) |
                   ({32{hit_mask_a}} & {20'h00000, mask_a_q}) |
                   ({32{hit_mask_b}} & {20'h00000, mask_b_q}) |
                   ({32{hit_swclr}} & {20'h00000, swclr_q}) |
                   ({32{hit_asrc}} & {29'h00000000, asrc_q}) |
                   ({32{hit_aen}} & {17'h00000, aen_q, 3'h0}) |
                   ({32{hit_stat}} & {4'h0, pend_vec, 4'h0, clr_state_vec}) |
                   ({32{hit_pwr}} & {20'h00000, pwr_q}) |
                   ({32{hit_data}} & {20'h00000, latch_rd}) |
                   ({32{hit_ccode}} & {20'h00000, ccode_rd});

  // read data captured in the wait cycle, valid when waitrequest drops
  always_ff @(posedge mclk)
  begin
    if (srst)
      rdata_q <= 32'h00000000;
    else if (avs_read && !ack_q)
      rdata_q <= rd_word;
  end

  assign avs_readdata = rdata_q;

  // analog stage outputs
  assign dac_code = code_vec;
  assign dac_gain_5x = gain_q;
  assign dac_buf_power_up = pwr_q;
  assign dac_cleared = clr_state_vec;

endmodule
`default_nettype wire

// ===== testbench/dlc_dac_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dlc_dac_ctrl_chk
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // register bus
  input wire logic [dlc_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins and alarms
  input wire logic hw_clear_in_a_n,
  input wire logic hw_clear_in_b_n,
  input wire logic [dlc_pkg::NSRC-1:0] alarm_in,
  // analog side
  input wire logic [dlc_pkg::NCH-1:0][dlc_pkg::DW-1:0] dac_code,
  input wire logic [dlc_pkg::NCH-1:0] dac_gain_5x,
  input wire logic [dlc_pkg::NCH-1:0] dac_buf_power_up,
  input wire logic [dlc_pkg::NCH-1:0] dac_cleared
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic [dlc_pkg::NCH-1:0][dlc_pkg::DW-1:0] code_q;
  // slot decode of the current access
  wire logic [3:0] slot = avs_address[5:2];
  wire logic rd_done = avs_read && !avs_waitrequest;
  // code as seen at read capture, since the latch may move meanwhile
  always_ff @(posedge mclk) code_q <= dac_code;

  reset_zero_a: assert property (disable iff (1'b0) srst |=> dac_code == '0)
    else $error("codes not zero after reset");
  data_readback_a: assert property (rd_done && avs_address[7:6] == 2'b01 && slot < 4'd12
    |-> avs_readdata[11:0] == code_q[slot]) else $error("data read not latch");
  trig_zero_a: assert property (rd_done && avs_address == dlc_pkg::OFF_CFG0 |->
    !avs_readdata[0]) else $error("trigger bit reads one");
  unmapped_zero_a: assert property (rd_done && avs_address[7:6] != 2'b00 && slot > 4'd11
    |-> avs_readdata == '0) else $error("spare channel slot not zero");
  latch_cause_a: assert property (!$stable(dac_code) |-> $past(avs_write) ||
    $past(avs_write, 2) || $past(avs_write, 3) || $changed(dac_cleared))
    else $error("latch moved without cause");
  clear_cause_a: assert property ((dac_cleared & ~$past(dac_cleared)) != '0 |->
    !$past(hw_clear_in_a_n, 3) || !$past(hw_clear_in_b_n, 3) || $past(|alarm_in) ||
    $past(|alarm_in, 2) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("clear without source");
  gain_write_a: assert property (!$stable(dac_gain_5x) |-> $past(avs_write) &&
    $past(avs_address) == dlc_pkg::OFF_GAIN) else $error("gain moved without write");
  power_write_a: assert property (!$stable(dac_buf_power_up) |-> $past(avs_write) &&
    $past(avs_address) == dlc_pkg::OFF_PWR) else $error("power moved without write");
  // main scenarios
  cover property (rd_done && avs_address[7:6] == 2'b01);
  cover property (dac_cleared != '0);
  cover property (avs_write && avs_address == dlc_pkg::OFF_CFG0 && avs_writedata[0]);
endmodule
bind dlc_dac_ctrl dlc_dac_ctrl_chk dlc_dac_ctrl_chk_i (.*);
`default_nettype wire

// ===== testbench/dlc_host.sv
`timescale 1ns/100ps
`default_nettype none
module dlc_host
(
  // clock
  input wire logic mclk,
  // avalon-mm master
  output logic [dlc_pkg::AW-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // clear pins and alarm levels
  output logic hw_clear_in_a_n,
  output logic hw_clear_in_b_n,
  output logic [dlc_pkg::NSRC-1:0] alarm_in
);
  // idle bus, pins released high
  initial
  begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    hw_clear_in_a_n = 1'b1;
    hw_clear_in_b_n = 1'b1;
    alarm_in = '0;
  end
  // one access, held until waitrequest is low; an idle edge first
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !we;
    avs_write <= we;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== testbench/dlc_dac_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dlc_dac_ctrl_tb;
  logic mclk;
  logic srst;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, hw_clear_in_a_n, hw_clear_in_b_n;
  logic [31:0] avs_writedata, avs_readdata, q, d;
  logic [3:0] avs_byteenable;
  logic [2:0] alarm_in;
  logic [11:0][11:0] dac_code;
  logic [11:0] dac_gain_5x, dac_buf_power_up, dac_cleared, syn, pend, clr, ma, mb;
  logic [11:0] inr [12];
  logic [11:0] lat [12];
  logic [11:0] cc [12];
  logic [31:0] seed = 32'd67589;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int k;

  dlc_dac_ctrl dlc_dac_ctrl_i (.*);
  dlc_host dlc_host_i (.*);

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // xorshift source, fixed start
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // visible code: clear code while cleared, else the latch model
  function logic [11:0] exp_code(int i);
    return clr[i] ? cc[i] : lat[i];
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    dlc_host_i.xfer(1'b1, a, v, q);
  endtask
  // settle past pin sync and latch, then compare every channel
  task check_all();
    repeat (5) @(posedge mclk);
    for (int i = 0; i < 12; i++)
    begin
      chk("code", dac_code[i], exp_code(i));
      chk("cleared", dac_cleared[i], clr[i]);
    end
  endtask
  // leaving clear restores the input register
  task set_clr(input logic [11:0] nc);
    for (int i = 0; i < 12; i++)
      if (clr[i] && !nc[i])
        lat[i] = inr[i];
    clr = nc;
    check_all();
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, far above the under one thousand cycles needed
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  initial
  begin
    srst = 1'b1;
    clr = '0;
    syn = '0;
    pend = '0;
    for (int i = 0; i < 12; i++)
    begin
      inr[i] = '0;
      lat[i] = '0;
    end
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      dlc_host_i.xfer(1'b0, dlc_pkg::OFF_DATA + 8'(4 * i), '0, q);
      chk("data", q, 32'h0);
    end
    chk("power", dac_buf_power_up, 32'h0);
    $display("test reset done");
    // random writes, mode changes and triggers
    for (int n = 0; n < 60; n++)
    begin
      k = rnd() % 12;
      d = rnd();
      case (rnd() % 4)
        0, 1:
        begin
          wr(dlc_pkg::OFF_DATA + 8'(4 * k), d);
          inr[k] = d[11:0];
          pend[k] = 1'b1;
          if (!syn[k])
            lat[k] = d[11:0];
        end
        2:
        begin
          wr(dlc_pkg::OFF_CFG0, 32'h1);
          for (int i = 0; i < 12; i++)
            if (syn[i] && pend[i])
              lat[i] = inr[i];
          pend = '0;
        end
        default:
        begin
          wr(dlc_pkg::OFF_SYNC, d);
          syn = d[11:0];
        end
      endcase
      check_all();
      dlc_host_i.xfer(1'b0, dlc_pkg::OFF_DATA + 8'(4 * k), '0, q);
      chk("readback", q, {20'h0, lat[k]});
    end
    $display("test load done");
    // pin clears, overlapping, then software clear
    for (int i = 0; i < 12; i++)
    begin
      cc[i] = 12'(rnd());
      wr(dlc_pkg::OFF_CCODE + 8'(4 * i), {20'h0, cc[i]});
    end
    ma = 12'(rnd());
    mb = 12'(rnd());
    wr(dlc_pkg::OFF_MASK_A, {20'h0, ma});
    wr(dlc_pkg::OFF_MASK_B, {20'h0, mb});
    dlc_host_i.hw_clear_in_a_n <= 1'b0;
    set_clr(ma);
    dlc_host_i.hw_clear_in_b_n <= 1'b0;
    set_clr(ma | mb);
    dlc_host_i.hw_clear_in_a_n <= 1'b1;
    set_clr(mb);
    dlc_host_i.hw_clear_in_b_n <= 1'b1;
    set_clr('0);
    k = rnd();
    wr(dlc_pkg::OFF_SWCLR, k);
    set_clr(k[11:0]);
    wr(dlc_pkg::OFF_SWCLR, 32'h0);
    set_clr('0);
    // each alarm source: unselected ones first, then all raised
    k = rnd();
    wr(dlc_pkg::OFF_AEN, k);
    for (int j = 0; j < 3; j++)
    begin
      wr(dlc_pkg::OFF_ASRC, 32'(1 << j));
      dlc_host_i.alarm_in <= ~3'(1 << j);
      set_clr('0);
      dlc_host_i.alarm_in <= 3'h7;
      set_clr(k[14:3]);
      dlc_host_i.alarm_in <= 3'h0;
      set_clr('0);
    end
    $display("test clear done");
    k = rnd();
    wr(dlc_pkg::OFF_GAIN, k);
    @(posedge mclk);
    chk("gain", dac_gain_5x, k[11:0]);
    wr(dlc_pkg::OFF_PWR, k >> 4);
    @(posedge mclk);
    chk("power", dac_buf_power_up, k[15:4]);
    dlc_host_i.xfer(1'b0, dlc_pkg::OFF_CFG0, '0, q);
    chk("trigger", q[0], 32'h0);
    dlc_host_i.xfer(1'b0, 8'h74, '0, q);
    chk("spare", q, 32'h0);
    $display("test misc done");
    wrap_up();
  end
endmodule
`default_nettype wire
